// *** scx_gate_check.sv ***
// Overview of operation
// [RULE1] Calls may only cross inward toward segment 0; returns only outward.
// [RULE2] Bad crossing: no execution, protection fault, code 7 outward call, 8 inward return.
// [RULE3] Interrupt from segment 0 serviced in segment 0 is no crossing.
// [RULE4] Gate array pointer sits in destination page zero, octal 34 and 35.
// [RULE5] Header bit 16 zero, low field is gate count; zero forbids entry.
// [RULE6] Gates follow header through doubleword n+1: bracket and PC offset.
// [RULE7] Effective address: segment bits 1-3, bit 16 zero, gate bits 17-31.
// [RULE8] Same-segment call jumps to the offset with no gate lookup.
// [RULE9] The 16-bit argument count sizes the overflow check.
// [RULE10] First check segment base validity; if clear, fault code 3.
// [RULE11] Continue only if gate number is below the gate count.
// [RULE12] Bracket compares current segment, or last indirect segment if indirect.
// [RULE13] On pass PC gets segment bits 1-3 and gate offset bits 4-31.
// [RULE14] Gate number or bracket failure: abort, code 6, source segment fault.
// [RULE15] Save frame and stack pointers to source page zero after validation.
// [RULE16] Load stack pointer, limit and base from destination; frame pointer untouched.
// [RULE17] Page fault on page zero means infinite page fault and halt.
// [RULE18] Software keeps live stack limit and base equal to saved copies.
// [RULE19] Overflow: no copy, code 2, stack fault in destination, PC at entry.
// [RULE20] Jump-to-subroutine puts return address in the return accumulator.
// [RULE21] Return block last doubleword: carry in bit 0, return PC bits 1-31.
// [RULE22] Checks in order validity, count, bracket, overflow; first failure ends.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module scx_gate_check
    import scx_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            start,
    input  wire scx_pkg::scx_req_t req_in,
    output logic                 ready,
    output logic                 done,
    output scx_pkg::scx_res_t    result,
    output logic                 halted,
    input  wire logic [7:0]      seg_valid,
    output logic                 mem_req,
    output logic                 mem_we,
    output logic [31:0]          mem_addr,
    output logic [31:0]          mem_wdata,
    input  wire logic            mem_ack,
    input  wire logic [31:0]     mem_rdata,
    input  wire logic            mem_page_fault,
    input  wire logic [1:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata
);
    import scx_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_CHECK = 4'b0001,
        ST_PTR   = 4'b0010,
        ST_HDR   = 4'b0011,
        ST_GATE  = 4'b0100,
        ST_SVFP  = 4'b0101,
        ST_SVSP  = 4'b0110,
        ST_LDSP  = 4'b0111,
        ST_LDSL  = 4'b1000,
        ST_LDSB  = 4'b1001,
        ST_OVF   = 4'b1010,
        ST_HALT  = 4'b1011
    } scx_state_t;

    typedef struct packed {
        scx_state_t  state;
        scx_req_t    req;
        scx_res_t    res;
        logic [31:0] gptr;
        logic [14:0] gcount;
        logic        done;
        logic        enable;
        logic [31:0] rdata;
    } scx_st_t;

    // ============================================================
    // Reset release
    logic rst_m_r;
    logic rst_s_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end
        else
        begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end

    // ============================================================
    // Sequencer
    scx_st_t     s_r;
    scx_st_t     s_nxt;
    logic [2:0]  dseg;
    logic [2:0]  src_seg;
    logic [14:0] gate;
    logic [32:0] ovf_sum;
    logic        overflow;
    logic        xfer;
    logic        fail;
    logic [15:0] fcode;
    scx_fkind_t  fkind;
    logic [2:0]  fseg;

    assign dseg     = s_r.req.ea[30:28];                        // [RULE7]
    assign gate     = s_r.req.ea[14:0];                         // [RULE7]
    assign src_seg  = s_r.req.indirect ? s_r.req.ind_seg : s_r.req.cur_seg; // [RULE12]
    assign ovf_sum  = {1'b0, s_r.res.wsp} + {16'h0000, s_r.req.arg_count, 1'b0}; // [RULE9]
    assign overflow = ovf_sum > {1'b0, s_r.res.wsl};
    assign xfer     = mem_req && mem_ack;

    always_comb
    begin
        mem_req   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = 32'h00000000;
        mem_wdata = 32'h00000000;
        case (s_r.state)
            ST_PTR:
            begin
                mem_req  = 1'b1;
                mem_addr = pz_addr(dseg, PZ_GATE_PTR);          // [RULE4]
            end
            ST_HDR:
            begin
                mem_req  = 1'b1;
                mem_addr = s_r.gptr;
            end
            ST_GATE:
            begin
                mem_req  = 1'b1;
                mem_addr = s_r.gptr + {16'h0000, gate, 1'b0} + 32'h00000002; // [RULE6]
            end
            ST_SVFP:
            begin
                mem_req   = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = pz_addr(s_r.req.cur_seg, PZ_WFP);   // [RULE15]
                mem_wdata = s_r.req.wide_frame_pointer;
            end
            ST_SVSP:
            begin
                mem_req   = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = pz_addr(s_r.req.cur_seg, PZ_WSP);   // [RULE15]
                mem_wdata = s_r.req.wsp;
            end
            ST_LDSP:
            begin
                mem_req  = 1'b1;
                mem_addr = pz_addr(dseg, PZ_WSP);               // [RULE16]
            end
            ST_LDSL:
            begin
                mem_req  = 1'b1;
                mem_addr = pz_addr(dseg, PZ_WSL);
            end
            ST_LDSB:
            begin
                mem_req  = 1'b1;
                mem_addr = pz_addr(dseg, PZ_WSB);
            end
            default:
            begin
                mem_req = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        fail       = 1'b0;
        fcode      = FC_NONE;
        fkind      = FK_PROT;
        fseg       = s_r.req.cur_seg;
        if (xfer && mem_page_fault)
        begin
            s_nxt.state = ST_HALT;                              // [RULE17]
        end
        else
        begin
            case (s_r.state)
                ST_IDLE:
                begin
                    if (start && ready)
                    begin
                        s_nxt.req   = req_in;
                        s_nxt.res   = '0;
                        s_nxt.state = ST_CHECK;
                    end
                end
                ST_CHECK:
                begin
                    s_nxt.res.pc = s_r.req.ea;
                    s_nxt.state  = ST_IDLE;
                    s_nxt.done   = 1'b1;
                    case (s_r.req.kind)
                        KIND_CALL:
                        begin
                            if (dseg > s_r.req.cur_seg)
                            begin
                                fail  = 1'b1;                   // [RULE1] [RULE2]
                                fcode = FC_OUT_CALL;
                            end
                            else if (dseg == s_r.req.cur_seg)
                            begin
                                s_nxt.res.pc = {1'b0, dseg, 13'h0000, gate}; // [RULE8]
                            end
                            else if (!seg_valid[dseg])
                            begin
                                fail  = 1'b1;                   // [RULE10] [RULE22]
                                fcode = FC_SEG_BAD;
                            end
                            else
                            begin
                                s_nxt.done  = 1'b0;
                                s_nxt.state = ST_PTR;
                            end
                        end
                        KIND_JSR:
                        begin
                            s_nxt.res.ret_acc = s_r.req.ret_pc; // [RULE20]
                            s_nxt.res.ret_dw  = {s_r.req.carry, s_r.req.ret_pc[30:0]}; // [RULE21]
                        end
                        default:
                        begin
                            // Equal segments, e.g. ring 0 to ring 0, is no crossing
                            if (dseg < s_r.req.cur_seg)
                            begin
                                fail  = 1'b1;                   // [RULE1] [RULE2] [RULE3]
                                fcode = FC_IN_RET;
                            end
                        end
                    endcase
                end
                ST_PTR:
                begin
                    if (xfer)
                    begin
                        s_nxt.gptr  = mem_rdata;
                        s_nxt.state = ST_HDR;
                    end
                end
                ST_HDR:
                begin
                    if (xfer)
                    begin
                        // A set bit 16 is a malformed header; it closes the segment
                        s_nxt.gcount = mem_rdata[15] ? 15'h0000 : mem_rdata[14:0]; // [RULE5]
                        if (mem_rdata[15] || gate >= mem_rdata[14:0])
                        begin
                            fail  = 1'b1;                       // [RULE11] [RULE14]
                            fcode = FC_GATE;
                        end
                        else
                        begin
                            s_nxt.state = ST_GATE;
                        end
                    end
                end
                ST_GATE:
                begin
                    if (xfer)
                    begin
                        if (src_seg <= mem_rdata[30:28])        // [RULE12]
                        begin
                            s_nxt.res.pc = {1'b0, dseg, mem_rdata[27:0]}; // [RULE13]
                            s_nxt.state  = ST_SVFP;
                        end
                        else
                        begin
                            fail  = 1'b1;                       // [RULE14]
                            fcode = FC_GATE;
                        end
                    end
                end
                ST_SVFP:
                begin
                    if (xfer)
                    begin
                        s_nxt.state = ST_SVSP;
                    end
                end
                ST_SVSP:
                begin
                    if (xfer)
                    begin
                        s_nxt.state = ST_LDSP;
                    end
                end
                ST_LDSP:
                begin
                    if (xfer)
                    begin
                        s_nxt.res.wsp = mem_rdata;
                        s_nxt.state   = ST_LDSL;
                    end
                end
                ST_LDSL:
                begin
                    if (xfer)
                    begin
                        s_nxt.res.wsl = mem_rdata;
                        s_nxt.state   = ST_LDSB;
                    end
                end
                ST_LDSB:
                begin
                    if (xfer)
                    begin
                        s_nxt.res.wsb          = mem_rdata;
                        s_nxt.res.stack_loaded = 1'b1;          // [RULE16]
                        s_nxt.state            = ST_OVF;
                    end
                end
                ST_OVF:
                begin
                    s_nxt.state = ST_IDLE;
                    s_nxt.done  = 1'b1;
                    s_nxt.res.ret_dw = {s_r.req.carry, s_r.res.pc[30:0]}; // [RULE21]
                    if (overflow)
                    begin
                        fail  = 1'b1;                           // [RULE19]
                        fcode = FC_STACK;
                        fkind = FK_STACK;
                        fseg  = dseg;
                    end
                end
                ST_HALT:
                begin
                    s_nxt.state = ST_HALT;
                end
                default:
                begin
                    s_nxt.state = ST_IDLE;
                end
            endcase
        end
        if (fail)
        begin
            s_nxt.state          = ST_IDLE;                     // [RULE22]
            s_nxt.done           = 1'b1;
            s_nxt.res.fkind      = fkind;
            s_nxt.res.fault_code = fcode;
            s_nxt.res.fault_seg  = fseg;
        end
        // Register port; reads answer in the following cycle only
        if (reg_wr && reg_addr == REG_CTRL)
        begin
            s_nxt.enable = reg_wdata[0];
        end
        s_nxt.rdata = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                REG_CTRL:   s_nxt.rdata = {31'h00000000, s_r.enable};
                REG_STATUS: s_nxt.rdata = {24'h000000, s_r.res.fkind, s_r.state == ST_HALT,
                                           s_r.state != ST_IDLE, s_r.state};
                REG_FAULT:  s_nxt.rdata = {13'h0000, s_r.res.fault_seg, s_r.res.fault_code};
                default:    s_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_s_r)
    begin
        if (!rst_s_r)
        begin
            s_r        <= '0;
            s_r.enable <= CTRL_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ready     = (s_r.state == ST_IDLE) && s_r.enable;
    assign done      = s_r.done;
    assign result    = s_r.res;
    assign halted    = s_r.state == ST_HALT;
    assign reg_rdata = s_r.rdata;

    // ============================================================
    // Checks
    out_call_a: assert property ( // [RULE2]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_CHECK && s_r.req.kind == KIND_CALL && dseg > s_r.req.cur_seg
        |=> done && result.fault_code == FC_OUT_CALL && result.fkind == FK_PROT)
        else $error("outward call not faulted with code 7");

    in_ret_a: assert property ( // [RULE1]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_CHECK && s_r.req.kind != KIND_CALL && s_r.req.kind != KIND_JSR
        && dseg < s_r.req.cur_seg
        |=> done && result.fault_code == FC_IN_RET)
        else $error("inward return not faulted with code 8");

    seg_bad_a: assert property ( // [RULE10]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_CHECK && s_r.req.kind == KIND_CALL && dseg < s_r.req.cur_seg
        && !seg_valid[dseg]
        |=> done && result.fault_code == FC_SEG_BAD && !$past(mem_req))
        else $error("invalid segment not faulted with code 3");

    same_seg_a: assert property ( // [RULE8]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_CHECK && s_r.req.kind == KIND_CALL && dseg == s_r.req.cur_seg
        |=> done && result.fkind == FK_NONE && result.pc[14:0] == $past(gate))
        else $error("same segment call did not jump directly");

    ptr_addr_a: assert property ( // [RULE4]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_PTR |-> mem_req && !mem_we && mem_addr[27:0] == PZ_GATE_PTR
        && mem_addr[30:28] == dseg)
        else $error("gate pointer read at wrong address");

    gate_bound_a: assert property ( // [RULE11]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_HDR && xfer && !mem_page_fault && gate >= mem_rdata[14:0]
        |=> done && result.fault_code == FC_GATE)
        else $error("gate number beyond count not faulted");

    pz_halt_a: assert property ( // [RULE17]
        @(posedge clk) disable iff (!rst_s_r)
        xfer && mem_page_fault |=> halted [*3])
        else $error("page fault did not halt");

    save_seq_a: assert property ( // [RULE15]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_SVFP && xfer && !mem_page_fault
        |=> mem_we && mem_wdata == s_r.req.wsp && mem_addr[30:28] == s_r.req.cur_seg)
        else $error("stack pointer save out of order");

    ovf_a: assert property ( // [RULE19]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_OVF && overflow
        |=> done && result.fault_code == FC_STACK && result.fkind == FK_STACK
        && result.fault_seg == $past(dseg) && result.ret_dw[30:0] == result.pc[30:0])
        else $error("stack overflow not faulted in destination");

    jsr_a: assert property ( // [RULE20]
        @(posedge clk) disable iff (!rst_s_r)
        s_r.state == ST_CHECK && s_r.req.kind == KIND_JSR
        |=> result.ret_acc == $past(s_r.req.ret_pc) && result.ret_dw[31] == $past(s_r.req.carry))
        else $error("return address accumulator not loaded");

endmodule

// *** scx_pkg.sv ***
package scx_pkg;

    // ============================================================
    // Page-zero layout, word offsets
    localparam logic [27:0] PZ_GATE_PTR = 28'h000001c;
    localparam logic [27:0] PZ_WFP      = 28'h0000010;
    localparam logic [27:0] PZ_WSP      = 28'h0000012;
    localparam logic [27:0] PZ_WSL      = 28'h0000014;
    localparam logic [27:0] PZ_WSB      = 28'h0000016;

    // ============================================================
    // Fault codes
    localparam logic [15:0] FC_NONE     = 16'h0000;
    localparam logic [15:0] FC_STACK    = 16'h0002;
    localparam logic [15:0] FC_SEG_BAD  = 16'h0003;
    localparam logic [15:0] FC_GATE     = 16'h0006;
    localparam logic [15:0] FC_OUT_CALL = 16'h0007;
    localparam logic [15:0] FC_IN_RET   = 16'h0008;

    // ============================================================
    // Register port
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_FAULT  = 2'h2;
    localparam logic       CTRL_RST   = 1'h1;

    typedef enum logic [1:0] {
        KIND_CALL   = 2'b00,
        KIND_RETURN = 2'b01,
        KIND_INTR   = 2'b10,
        KIND_JSR    = 2'b11
    } scx_kind_t;

    typedef enum logic [1:0] {
        FK_NONE  = 2'b00,
        FK_PROT  = 2'b01,
        FK_STACK = 2'b10
    } scx_fkind_t;

    typedef struct packed {
        scx_kind_t   kind;
        logic [31:0] ea;
        logic [2:0]  cur_seg;
        logic        indirect;
        logic [2:0]  ind_seg;
        logic [15:0] arg_count;
        logic [31:0] wide_frame_pointer;
        logic [31:0] wsp;
        logic        carry;
        logic [31:0] ret_pc;
    } scx_req_t;

    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] wsp;
        logic [31:0] wsl;
        logic [31:0] wsb;
        logic        stack_loaded;
        scx_fkind_t  fkind;
        logic [15:0] fault_code;
        logic [2:0]  fault_seg;
        logic [31:0] ret_dw;
        logic [31:0] ret_acc;
    } scx_res_t;

    function automatic logic [31:0] pz_addr(input logic [2:0] seg, input logic [27:0] off);
        pz_addr = {1'b0, seg, off};
    endfunction

endpackage

// *** scx_mem_model.sv ***
`timescale 1ns/1ns
module scx_mem_model (
    input  wire logic        clk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output logic             mem_page_fault
);
    logic [31:0] store [logic [31:0]];
    logic [31:0] pf_addr = 32'hffff_ffff;
    int          lat = 0;
    int          cnt = 0;

    initial
    begin
        mem_ack = 1'h0;
        mem_rdata = 32'h0;
        mem_page_fault = 1'h0;
    end

    // ============================================================
    // Ack after lat idle cycles, one cycle long
    always @(posedge clk)
    begin
        mem_ack <= 1'h0;
        mem_page_fault <= 1'h0;
        // Stale data flips so nothing can lean on it after the ack
        mem_rdata <= ~mem_rdata;
        if (mem_req && mem_ack && mem_we)
            store[mem_addr] = mem_wdata;
        else if (mem_req && !mem_ack && cnt < lat)
            cnt++;
        else if (mem_req && !mem_ack)
        begin
            cnt = 0;
            mem_ack <= 1'h1;
            mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : ~mem_addr;
            // Page zero stays resident unless a fault is planted on purpose
            mem_page_fault <= mem_addr == pf_addr;
        end
    end
endmodule

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
    import scx_pkg::*;
    logic clk = 1'h0, rst_b = 1'h0, start = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [1:0] reg_addr = 2'h0;
    logic [31:0] reg_wdata = 32'h0, seed = 32'h1733;
    logic [7:0] seg_valid = 8'hff;
    scx_req_t req_in = '0;
    scx_res_t res;
    logic ready, done, halted, mreq, mwe, mack, mpf;
    logic [31:0] maddr, mwd, mrd, reg_rdata;
    int miscompares = 0, checked = 0, n;

    always #5 clk = ~clk;
    scx_gate_check uut (.clk(clk), .rst_b(rst_b), .start(start), .req_in(req_in), .ready(ready), .done(done),
        .result(res), .halted(halted), .seg_valid(seg_valid), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr),
        .mem_wdata(mwd), .mem_ack(mack), .mem_rdata(mrd), .mem_page_fault(mpf), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    scx_mem_model mem (.clk(clk), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd),
        .mem_ack(mack), .mem_rdata(mrd), .mem_page_fault(mpf));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] pz(input logic [2:0] s, input logic [27:0] o);
        return {1'h0, s, o};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic reg_op(input logic wr, input logic [1:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        @(negedge clk);
        if (!wr)
            chk("reg_rdata", reg_rdata, exp);
    endtask

    // ============================================================
    // One transfer with its expected outcome
    task automatic op(input scx_kind_t k, input logic [2:0] c, input logic [31:0] ea, input logic ind,
                      input logic [2:0] is, input logic [15:0] arg);
        scx_req_t r;
        logic [2:0] d;
        logic [15:0] fc;
        logic [31:0] pc, ew, pw, ps;
        logic sv;
        d = ea[30:28];
        seed = lfsr(seed);
        r = '{k, ea, c, ind, is, arg, seed, 32'h400 + 32'({seed[3:0], 1'h0}), seed[5], ~seed};
        mem.lat = int'(seed[9:8]);
        for (n = 0; n < 99 && ready !== 1'h1; n++)
            @(negedge clk);
        @(posedge clk);
        start <= 1'h1;
        req_in <= r;
        ew = mem.store[pz(d, PZ_WSP)];
        pw = mem.store[pz(c, PZ_WFP)];
        ps = mem.store[pz(c, PZ_WSP)];
        pc = ea;
        fc = FC_NONE;
        if (k == KIND_RETURN || k == KIND_INTR)
            fc = d < c ? FC_IN_RET : FC_NONE;
        else if (k == KIND_CALL)
        begin
            if (d > c)
                fc = FC_OUT_CALL;
            else if (d == c)
                pc = {1'h0, c, 13'h0, ea[14:0]};
            else if (!seg_valid[d])
                fc = FC_SEG_BAD;
            else if (ea[14:0] >= 15'(d) || (ind ? is : c) > 3'(d + ea[2:0]))
                fc = FC_GATE;
            else
            begin
                pc = {1'h0, d, 28'h2000 + 28'(ea[14:0])};
                if (ew + 32'(arg) * 2 > 32'h400 + 32'(d) * 8)
                    fc = FC_STACK;
            end
        end
        sv = k == KIND_CALL && d < c && (fc == FC_NONE || fc == FC_STACK);
        @(posedge clk);
        start <= 1'h0;
        for (n = 0; n < 300 && done !== 1'h1; n++)
            @(negedge clk);
        chk("done", done, 1'h1);
        chk("fault_code", res.fault_code, fc);
        chk("fkind", res.fkind, fc == FC_NONE ? FK_NONE : fc == FC_STACK ? FK_STACK : FK_PROT);
        if (fc == FC_NONE || fc == FC_STACK)
            chk("pc", res.pc, pc);
        if (fc == FC_STACK)
            chk("fault_seg", res.fault_seg, d);
        if (fc != FC_NONE && fc != FC_STACK)
            chk("fault_seg", res.fault_seg, c);
        chk("ret_acc", res.ret_acc, k == KIND_JSR ? r.ret_pc : 32'h0);
        if (k == KIND_JSR || sv)
            chk("ret_dw", res.ret_dw, {r.carry, k == KIND_JSR ? r.ret_pc[30:0] : pc[30:0]});
        chk("saved wfp", mem.store[pz(c, PZ_WFP)], sv ? r.wide_frame_pointer : pw);
        chk("saved wsp", mem.store[pz(c, PZ_WSP)], sv ? r.wsp : ps);
        chk("stack_loaded", res.stack_loaded, sv);
        if (sv && fc == FC_NONE)
            chk("dest stack", res.wsl ^ res.wsp ^ res.wsb, (32'h400 + 32'(d) * 8) ^ ew ^ 32'h300);
        @(negedge clk);
        chk("done pulse", done, 1'h0);
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        for (int s = 0; s < 8; s++)
        begin
            mem.store[pz(3'(s), PZ_GATE_PTR)] = pz(3'(s), 28'h100);
            mem.store[pz(3'(s), 28'h100)] = {16'ha5a5, 1'h0, 15'(s)};
            for (int g = 0; g < s; g++)
                mem.store[pz(3'(s), 28'h102 + 28'(2 * g))] = {1'h1, 3'(s + g), 28'h2000 + 28'(g)};
            mem.store[pz(3'(s), PZ_WFP)] = 32'h0;
            mem.store[pz(3'(s), PZ_WSP)] = 32'h400;
            mem.store[pz(3'(s), PZ_WSL)] = 32'h400 + 32'(8 * s);
            mem.store[pz(3'(s), PZ_WSB)] = 32'h300;
        end
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        reg_op(1'h0, REG_CTRL, 32'h0, 32'h1);
        op(KIND_CALL, 3'h2, pz(3'h5, 28'h0), 1'h0, 3'h0, 16'h0);
        reg_op(1'h0, REG_FAULT, 32'h0, {13'h0, 3'h2, 16'h7});
        reg_op(1'h0, 2'h3, 32'h0, 32'h0);
        op(KIND_RETURN, 3'h5, pz(3'h2, 28'h40), 1'h0, 3'h0, 16'h0);
        op(KIND_RETURN, 3'h2, pz(3'h5, 28'h40), 1'h0, 3'h0, 16'h0);
        op(KIND_INTR, 3'h0, pz(3'h0, 28'h80), 1'h0, 3'h0, 16'h0);
        op(KIND_CALL, 3'h4, {1'h1, 3'h4, 12'hfff, 1'h0, 15'h1234}, 1'h0, 3'h0, 16'h0);
        op(KIND_JSR, 3'h1, pz(3'h1, 28'h500), 1'h0, 3'h0, 16'h0);
        op(KIND_CALL, 3'h3, pz(3'h0, 28'h0), 1'h0, 3'h0, 16'h0);
        op(KIND_CALL, 3'h5, pz(3'h3, 28'h3), 1'h0, 3'h0, 16'h0);
        op(KIND_CALL, 3'h5, {1'h1, 3'h3, 12'h0, 1'h0, 15'h2}, 1'h0, 3'h0, 16'hc);
        op(KIND_CALL, 3'h5, pz(3'h3, 28'h2), 1'h0, 3'h0, 16'hd);
        op(KIND_CALL, 3'h6, pz(3'h3, 28'h2), 1'h0, 3'h0, 16'h0);
        op(KIND_CALL, 3'h7, pz(3'h3, 28'h2), 1'h1, 3'h5, 16'h0);
        op(KIND_CALL, 3'h4, pz(3'h3, 28'h2), 1'h1, 3'h6, 16'h0);
        @(posedge clk);
        seg_valid <= 8'hbf;
        op(KIND_CALL, 3'h7, pz(3'h6, 28'h0), 1'h0, 3'h0, 16'h0);
        reg_op(1'h1, REG_CTRL, 32'h0, 32'h0);
        chk("ready disabled", ready, 1'h0);
        reg_op(1'h1, REG_CTRL, 32'h1, 32'h0);
        for (int i = 0; i < 120; i++)
        begin
            seed = lfsr(seed);
            @(posedge clk);
            seg_valid <= seed[4:0] == 5'h0 ? 8'hf7 : 8'hff;
            op(seed[6:5] == 2'h2 ? KIND_CALL : scx_kind_t'(seed[6:5]), seed[9:7],
               {seed[31], seed[12:10], seed[27:16], 1'h0, 12'h0, seed[15:13]}, seed[16], seed[19:17],
               16'(seed[24:20]));
        end
        mem.pf_addr = pz(3'h1, PZ_GATE_PTR);
        @(posedge clk);
        start <= 1'h1;
        req_in <= '{KIND_CALL, pz(3'h1, 28'h0), 3'h4, 1'h0, 3'h0, 16'h0, 32'h0, 32'h400, 1'h0, 32'h0};
        @(posedge clk);
        start <= 1'h0;
        for (n = 0; n < 100 && halted !== 1'h1; n++)
            @(negedge clk);
        chk("halted", halted, 1'h1);
        chk("ready halted", ready, 1'h0);
        reg_op(1'h0, REG_STATUS, 32'h0, {24'h0, 2'h0, 1'h1, 1'h1, 4'hb});
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
